// >>> tmr16_capture_compare.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - first compare at zero fires as count steps 0 to 1 after wrap.
// - first match irq also on match, second edge, one-shot clear.
// - pin b is either second edge input or timer output, never both.
// - read colliding with capture may return old data; capture is correct.
// - capture while stopping gives an undefined value.
// - second compare at zero fires as count steps 0 to 1 after wrap.
// - second match irq also on match, first edge, one-shot clear.
// - second capture/compare is writable while counting, takes effect live.
// - nonzero mode bits start the counter; zero stops it.
// - first edge input polarity comes from the prescaler register.
// - overflow flag sets on wrap from ffff to 0000.
module tmr16_capture_compare #(
  parameter int CNT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [tmr16_pkg::ADDR_W-1:0] i_addr,
  input wire logic [tmr16_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [tmr16_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_edge_input_first,
  input wire logic i_shared_port_pin_b,
  output logic o_shared_port_pin_b,
  output logic o_shared_port_pin_b_oe,
  output logic o_match_irq_first,
  output logic o_match_irq_second
);
  import tmr16_pkg::*;

  // ==========================================
  // elaboration check
  if (CNT_W != DATA_W) begin : g_bad_width
    $error("counter width must equal bus data width");
  end

  // ==========================================
  // state
  logic [CNT_W-1:0] main_up_counter_ff;
  logic [CNT_W-1:0] nxt_counter;
  logic [CNT_W-1:0] capcmp_reg_first_ff;
  logic [CNT_W-1:0] capcmp_reg_second_ff;
  mode_ctrl_t timer_mode_ctrl_reg_ff;
  capcmp_ctrl_t capcmp_control_reg_ff;
  prescale_t prescaler_mode_reg_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic wrapped_ff;
  logic timer_out_ff;
  logic irq_first_ff;
  logic irq_second_ff;

  // ==========================================
  // decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a == b;
  endfunction
  function automatic logic cmp_fire(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cr,
                                    input logic wrapped);
    // a zero compare only counts once the counter has wrapped
    return (cnt == cr) && ((cnt != RST_WORD) || wrapped);
  endfunction

  logic wr_cr_first;
  logic wr_cr_second;
  logic wr_mode;
  logic wr_crc;
  logic wr_prm;
  logic running;
  logic tick;
  logic edge_first;
  logic edge_second;
  logic edge_second_raw;
  logic one_shot_clear;
  logic match_first;
  logic match_second;
  logic wrap;
  logic edge_clear;
  logic match_clear;
  mode_ctrl_t wr_mode_val;
  capcmp_ctrl_t wr_crc_val;
  prescale_t wr_prm_val;
  // the counter index is read-only, so no write decode for it
  assign wr_cr_first = i_wr && hit(i_addr, ADDR_CAPCMP_FIRST);
  assign wr_cr_second = i_wr && hit(i_addr, ADDR_CAPCMP_SECOND);
  assign wr_mode = i_wr && hit(i_addr, ADDR_MODE_CTRL);
  assign wr_crc = i_wr && hit(i_addr, ADDR_CAPCMP_CTRL);
  assign wr_prm = i_wr && hit(i_addr, ADDR_PRESCALE);
  assign wr_mode_val = mode_ctrl_t'(i_wdata);
  assign wr_crc_val = capcmp_ctrl_t'(i_wdata);
  assign wr_prm_val = prescale_t'(i_wdata);
  assign running = timer_mode_ctrl_reg_ff.mode_sel != MODE_STOP;

  // ==========================================
  // prescaler and edge qualifiers
  tmr16_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_run(running),
    .i_div_sel(prescaler_mode_reg_ff.div_sel),
    .o_tick(tick)
  );

  tmr16_edge_detect u_edge_first (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_edge_input_first),
    .i_tick(tick),
    .i_sel(prescaler_mode_reg_ff.edge_first),
    .o_edge(edge_first)
  );

  tmr16_edge_detect u_edge_second (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_shared_port_pin_b),
    .i_tick(tick),
    .i_sel(prescaler_mode_reg_ff.edge_second),
    .o_edge(edge_second_raw)
  );

  assign edge_second = edge_second_raw && !timer_mode_ctrl_reg_ff.pin_b_is_output;
  assign o_shared_port_pin_b = timer_out_ff;
  assign o_shared_port_pin_b_oe = timer_mode_ctrl_reg_ff.pin_b_is_output;

  // ==========================================
  // counting
  assign one_shot_clear = running && wr_mode && wr_mode_val.one_shot;
  assign match_first = tick && !capcmp_control_reg_ff.first_capture &&
                       cmp_fire(main_up_counter_ff, capcmp_reg_first_ff, wrapped_ff);
  assign match_second = tick && !capcmp_control_reg_ff.second_capture &&
                        cmp_fire(main_up_counter_ff, capcmp_reg_second_ff, wrapped_ff);
  assign match_clear = tick && (timer_mode_ctrl_reg_ff.mode_sel == MODE_MATCH_CLEAR) &&
                       (main_up_counter_ff == capcmp_reg_first_ff);
  assign edge_clear = edge_first && (timer_mode_ctrl_reg_ff.mode_sel == MODE_EDGE_CLEAR);
  assign wrap = tick && (main_up_counter_ff == MAX_COUNT);

  always_comb begin
    nxt_counter = main_up_counter_ff;
    if (!running) begin
      nxt_counter = RST_WORD;
    end else if (one_shot_clear || edge_clear || match_clear) begin
      nxt_counter = RST_WORD;
    end else if (tick) begin
      nxt_counter = main_up_counter_ff + CNT_W'(1);
    end
  end

  // ==========================================
  // read path
  always_comb begin
    case (i_addr)
      ADDR_COUNT: nxt_rdata = main_up_counter_ff;
      ADDR_CAPCMP_FIRST: nxt_rdata = capcmp_reg_first_ff;
      ADDR_CAPCMP_SECOND: nxt_rdata = capcmp_reg_second_ff;
      // one-shot bit is never stored, so it always reads zero
      ADDR_MODE_CTRL: nxt_rdata = timer_mode_ctrl_reg_ff;
      ADDR_CAPCMP_CTRL: nxt_rdata = capcmp_control_reg_ff;
      ADDR_PRESCALE: nxt_rdata = prescaler_mode_reg_ff;
      default: nxt_rdata = RST_WORD;
    endcase
  end
  assign o_rdata = rdata_ff;
  assign o_match_irq_first = irq_first_ff;
  assign o_match_irq_second = irq_second_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_ff <= RST_WORD;
    end else if (i_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      main_up_counter_ff <= RST_WORD;
      wrapped_ff <= 1'b0;
    end else begin
      main_up_counter_ff <= nxt_counter;
      wrapped_ff <= running && (wrapped_ff || wrap);
    end
  end

  // ==========================================
  // capture/compare registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      capcmp_reg_first_ff <= RST_WORD;
    end else if (capcmp_control_reg_ff.first_capture && edge_second) begin
      capcmp_reg_first_ff <= main_up_counter_ff;
    end else if (wr_cr_first) begin
      capcmp_reg_first_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      capcmp_reg_second_ff <= RST_WORD;
    end else if (capcmp_control_reg_ff.second_capture && edge_first) begin
      capcmp_reg_second_ff <= main_up_counter_ff;
    end else if (wr_cr_second) begin
      capcmp_reg_second_ff <= i_wdata;
    end
  end

  // ==========================================
  // control registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_mode_ctrl_reg_ff <= mode_ctrl_t'(RST_WORD);
      capcmp_control_reg_ff <= capcmp_ctrl_t'(RST_WORD);
      prescaler_mode_reg_ff <= prescale_t'(RST_WORD);
    end else begin
      if (wr_mode) begin
        timer_mode_ctrl_reg_ff.mode_sel <= wr_mode_val.mode_sel;
        timer_mode_ctrl_reg_ff.pin_b_is_output <= wr_mode_val.pin_b_is_output;
      end
      if (wrap) begin
        timer_mode_ctrl_reg_ff.overflow <= 1'b1;
      end else if (wr_mode) begin
        timer_mode_ctrl_reg_ff.overflow <= wr_mode_val.overflow;
      end
      if (wr_crc) begin
        capcmp_control_reg_ff.first_capture <= wr_crc_val.first_capture;
        capcmp_control_reg_ff.second_capture <= wr_crc_val.second_capture;
      end
      if (wr_prm) begin
        prescaler_mode_reg_ff.div_sel <= wr_prm_val.div_sel;
        prescaler_mode_reg_ff.edge_first <= wr_prm_val.edge_first;
        prescaler_mode_reg_ff.edge_second <= wr_prm_val.edge_second;
      end
    end
  end

  // ==========================================
  // interrupts and timer output
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_first_ff <= 1'b0;
      irq_second_ff <= 1'b0;
      timer_out_ff <= 1'b0;
    end else begin
      irq_first_ff <= match_first || edge_second || one_shot_clear;
      irq_second_ff <= match_second || edge_first || one_shot_clear;
      if (!running) begin
        timer_out_ff <= 1'b0;
      end else if (match_first) begin
        timer_out_ff <= !timer_out_ff;
      end
    end
  end

  // ==========================================
  // assertions
  property p_stop_clears;
    @(posedge i_clk) disable iff (!i_reset_n)
    !running |=> main_up_counter_ff == RST_WORD;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("counter not held at zero");
  property p_count_step;
    @(posedge i_clk) disable iff (!i_reset_n)
    (tick && !one_shot_clear && !edge_clear && !match_clear && !wr_mode)
      |=> main_up_counter_ff == $past(main_up_counter_ff) + CNT_W'(1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");
  property p_hold_no_tick;
    @(posedge i_clk) disable iff (!i_reset_n)
    (running && !tick && !one_shot_clear && !edge_clear && !wr_mode) |=> $stable(main_up_counter_ff);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("counter moved without tick");
  property p_ovf_set;
    @(posedge i_clk) disable iff (!i_reset_n)
    wrap |=> timer_mode_ctrl_reg_ff.overflow && main_up_counter_ff == RST_WORD;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missed");
  property p_zero_first;
    @(posedge i_clk) disable iff (!i_reset_n)
    (tick && wrapped_ff && main_up_counter_ff == RST_WORD && capcmp_reg_first_ff == RST_WORD &&
     !capcmp_control_reg_ff.first_capture) |=> o_match_irq_first;
  endproperty
  a_zero_first: assert property (p_zero_first) else $error("zero compare irq first missed");
  property p_zero_second;
    @(posedge i_clk) disable iff (!i_reset_n)
    (tick && wrapped_ff && main_up_counter_ff == RST_WORD && capcmp_reg_second_ff == RST_WORD &&
     !capcmp_control_reg_ff.second_capture) |=> o_match_irq_second;
  endproperty
  a_zero_second: assert property (p_zero_second) else $error("zero compare irq second missed");
  // every first irq source is either a count tick or a mode write
  property p_irq_first_cause;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_match_irq_first |-> $past(tick) || $past(wr_mode);
  endproperty
  a_irq_first_cause: assert property (p_irq_first_cause) else $error("stray first irq");
  property p_irq_second_edge;
    @(posedge i_clk) disable iff (!i_reset_n)
    edge_first |=> o_match_irq_second;
  endproperty
  a_irq_second_edge: assert property (p_irq_second_edge) else $error("edge irq missed");
  // own output toggles on pin b must never come back as a first irq
  property p_pin_excl;
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_shared_port_pin_b_oe && !match_first && !one_shot_clear) |=> !o_match_irq_first;
  endproperty
  a_pin_excl: assert property (p_pin_excl) else $error("pin b used both ways");
  property p_live_second;
    @(posedge i_clk) disable iff (!i_reset_n)
    (wr_cr_second && !(capcmp_control_reg_ff.second_capture && edge_first))
      |=> capcmp_reg_second_ff == $past(i_wdata) && $stable(running);
  endproperty
  a_live_second: assert property (p_live_second) else $error("second write lost");
  c_wrap: cover property (@(posedge i_clk) disable iff (!i_reset_n) wrap);
  c_capture: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    capcmp_control_reg_ff.first_capture && edge_second);
  c_match_clear: cover property (@(posedge i_clk) disable iff (!i_reset_n) match_clear);
endmodule // tmr16_capture_compare
`default_nettype wire

// >>> tmr16_pkg.sv
package tmr16_pkg;
  // ==========================================
  // register map (4-bit word index)
  localparam logic [3:0] ADDR_COUNT = 4'h0;
  localparam logic [3:0] ADDR_CAPCMP_FIRST = 4'h1;
  localparam logic [3:0] ADDR_CAPCMP_SECOND = 4'h2;
  localparam logic [3:0] ADDR_MODE_CTRL = 4'h3;
  localparam logic [3:0] ADDR_CAPCMP_CTRL = 4'h4;
  localparam logic [3:0] ADDR_PRESCALE = 4'h5;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // ==========================================
  // mode select codes
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_FREE_RUN = 2'h1;
  localparam logic [1:0] MODE_EDGE_CLEAR = 2'h2;
  localparam logic [1:0] MODE_MATCH_CLEAR = 2'h3;
  // ==========================================
  // edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h3;
  // ==========================================
  // reset value and maximum count
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] MAX_COUNT = 16'hffff;
  // mode control: [0] overflow, [2:1] mode, [3] pin b as timer output, [4] one-shot trigger
  typedef struct packed {
    logic [10:0] rsvd;
    logic one_shot;
    logic pin_b_is_output;
    logic [1:0] mode_sel;
    logic overflow;
  } mode_ctrl_t;
  // capcmp control: [0] first is capture, [1] second is capture
  typedef struct packed {
    logic [13:0] rsvd;
    logic second_capture;
    logic first_capture;
  } capcmp_ctrl_t;
  // prescaler: [1:0] divide select, [3:2] first edge, [5:4] second edge
  typedef struct packed {
    logic [9:0] rsvd;
    logic [1:0] edge_second;
    logic [1:0] edge_first;
    logic [1:0] div_sel;
  } prescale_t;
endpackage

// >>> tmr16_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tmr16_prescaler (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic [1:0] i_div_sel,
  output logic o_tick
);
  import tmr16_pkg::*;
  logic [7:0] div_ff;
  logic [7:0] nxt_div;
  logic [7:0] div_mask;
  // ==========================================
  // divide by 1, 2, 4 or 8
  assign div_mask = (8'h01 << i_div_sel) - 8'h01;
  assign nxt_div = i_run ? ((div_ff & div_mask) == div_mask ? 8'h00 : div_ff + 8'h01) : 8'h00;
  assign o_tick = i_run && ((div_ff & div_mask) == div_mask);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= nxt_div;
    end
  end
endmodule // tmr16_prescaler
`default_nettype wire

// >>> tmr16_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module tmr16_edge_detect (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  input wire logic i_tick,
  input wire logic [1:0] i_sel,
  output logic o_edge
);
  import tmr16_pkg::*;
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic stable_ff;
  logic smp0_ff;
  logic smp1_ff;
  logic acc_ff;
  logic qual;
  logic rise;
  logic fall;
  // ==========================================
  // sync, then require two count-clock samples to agree
  assign qual = i_tick && (smp0_ff == smp1_ff) && (smp1_ff != acc_ff);
  assign rise = qual && smp1_ff;
  assign fall = qual && !smp1_ff;
  assign o_edge = (i_sel == EDGE_RISE && rise) || (i_sel == EDGE_FALL && fall) ||
                  (i_sel == EDGE_BOTH && qual);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      stable_ff <= 1'b0;
      smp0_ff <= 1'b0;
      smp1_ff <= 1'b0;
      acc_ff <= 1'b0;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        stable_ff <= s3_ff;
      end
      if (i_tick) begin
        smp0_ff <= stable_ff;
        smp1_ff <= smp0_ff;
      end
      if (qual) begin
        acc_ff <= smp1_ff;
      end
    end
  end
endmodule // tmr16_edge_detect
`default_nettype wire

// >>> trig_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// external capture trigger sources
module trig_source #(
  parameter int HOLD_CLKS = 24
) (
  input wire logic i_clk,
  output logic o_level_first,
  output logic o_level_second
);
  initial begin
    o_level_first = 1'b0;
    o_level_second = 1'b0;
  end

  // pulses held long
  // level stays well past two slowest count clocks so sync and filter see it
  task automatic drive(input bit second, input bit lvl);
    @(posedge i_clk);
    if (second) begin
      o_level_second <= lvl;
    end else begin
      o_level_first <= lvl;
    end
    repeat (HOLD_CLKS) @(posedge i_clk);
  endtask
endmodule // trig_source
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_top;
  import tmr16_pkg::*;
  logic clk;
  logic reset_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic src_a;
  logic src_b;
  logic pin_out;
  logic pin_oe;
  logic irq1;
  logic irq2;
  wire logic pin_b;
  int bad_count;
  int n_checks;
  int n_irq1;
  int n_irq2;

  assign pin_b = pin_oe ? pin_out : src_b;

  tmr16_capture_compare uut (
    .i_clk(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_edge_input_first(src_a),
    .i_shared_port_pin_b(pin_b), .o_shared_port_pin_b(pin_out),
    .o_shared_port_pin_b_oe(pin_oe), .o_match_irq_first(irq1), .o_match_irq_second(irq2)
  );
  trig_source src (.i_clk(clk), .o_level_first(src_a), .o_level_second(src_b));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // pulses counted at the edge after they appear
  always @(posedge clk) begin
    if (irq1 === 1'b1) n_irq1++;
    if (irq2 === 1'b1) n_irq2++;
  end

  // ==========================================
  // bus and helpers
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  function automatic logic [15:0] mk_mode(input logic [1:0] sel, input logic oe,
                                          input logic os);
    mode_ctrl_t m;
    m = '0;
    m.mode_sel = sel;
    m.pin_b_is_output = oe;
    m.one_shot = os;
    return m;
  endfunction
  task automatic setup(input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] ctl,
                       input logic [15:0] pre, input logic [15:0] mode);
    wr_reg(ADDR_MODE_CTRL, 16'h0000);
    wr_reg(ADDR_CAPCMP_FIRST, c1);
    wr_reg(ADDR_CAPCMP_SECOND, c2);
    wr_reg(ADDR_CAPCMP_CTRL, ctl);
    wr_reg(ADDR_PRESCALE, pre);
    wr_reg(ADDR_MODE_CTRL, mode);
  endtask
  task automatic wait_irq(input bit second, input int bound, output int cyc);
    cyc = 0;
    while (cyc < bound) begin
      @(posedge clk);
      #1;
      cyc++;
      if ((second ? irq2 : irq1) === 1'b1) return;
    end
    bad_count++;
    $display("Error at %0t: match pulse never came", $time);
    conclude();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [15:0] rv;
    `CHK(pin_oe, 1'b0)
    for (int a = 0; a < 8; a++) begin
      rd_reg(4'(a), rv);
      `CHK(rv, RST_WORD)
    end
    wr_reg(ADDR_CAPCMP_SECOND, 16'h1234);
    rd_reg(ADDR_CAPCMP_SECOND, rv);
    `CHK(rv, 16'h1234)
    wr_reg(ADDR_PRESCALE, 16'h003f);
    rd_reg(ADDR_PRESCALE, rv);
    `CHK(rv, 16'h003f)
    $display("t_reset finished");
  endtask

  task automatic t_rate();
    logic [15:0] v0;
    logic [15:0] v1;
    for (int d = 0; d < 4; d++) begin
      setup(MAX_COUNT, MAX_COUNT, 16'h0000, 16'(d), mk_mode(MODE_FREE_RUN, 1'b0, 1'b0));
      rd_reg(ADDR_COUNT, v0);
      repeat (30) @(posedge clk);
      rd_reg(ADDR_COUNT, v1);
      `CHK(v1 - v0, 16'(32 >> d))
    end
    wr_reg(ADDR_MODE_CTRL, 16'h0000);
    rd_reg(ADDR_COUNT, v0);
    `CHK(v0, RST_WORD)
    $display("t_rate finished");
  endtask

  task automatic t_match_clear();
    int cyc;
    logic p0;
    setup(16'h001e, 16'h000a, 16'h0000, 16'h0000, mk_mode(MODE_MATCH_CLEAR, 1'b1, 1'b0));
    wait_irq(1'b0, 200, cyc);
    p0 = pin_b;
    wait_irq(1'b0, 200, cyc);
    `CHK(cyc, 31)
    `CHK(pin_b, ~p0)
    wait_irq(1'b1, 200, cyc);
    `CHK(cyc, 11)
    wr_reg(ADDR_CAPCMP_SECOND, 16'h0014);
    wait_irq(1'b0, 200, cyc);
    wait_irq(1'b1, 200, cyc);
    `CHK(cyc, 21)
    $display("t_match_clear finished");
  endtask

  task automatic t_edges();
    int exp_n[4] = '{1, 1, 2, 0};
    int n0;
    logic [15:0] v0;
    logic [15:0] v1;
    logic [15:0] rv;
    for (int e = 0; e < 4; e++) begin
      setup(MAX_COUNT, MAX_COUNT, 16'h0002, 16'(e << 2), mk_mode(MODE_FREE_RUN, 1'b0, 1'b0));
      rd_reg(ADDR_COUNT, v0);
      n0 = n_irq2;
      src.drive(1'b0, 1'b1);
      src.drive(1'b0, 1'b0);
      rd_reg(ADDR_COUNT, v1);
      `CHK(n_irq2 - n0, exp_n[e])
      if (e == 1) begin
        rd_reg(ADDR_CAPCMP_SECOND, rv);
        `CHK(rv > v0 && rv < v1, 1'b1)
      end
    end
    setup(MAX_COUNT, MAX_COUNT, 16'h0001, 16'h0010, mk_mode(MODE_FREE_RUN, 1'b0, 1'b0));
    n0 = n_irq1;
    src.drive(1'b1, 1'b1);
    src.drive(1'b1, 1'b0);
    `CHK(n_irq1 - n0, 1)
    // timer output toggles pin b; only the five-cycle matches may reach the first irq
    setup(16'h0004, MAX_COUNT, 16'h0000, 16'h0020, mk_mode(MODE_MATCH_CLEAR, 1'b1, 1'b0));
    n0 = n_irq1;
    repeat (50) @(posedge clk);
    `CHK(n_irq1 - n0, 9)
    `CHK(pin_oe, 1'b1)
    $display("t_edges finished");
  endtask

  task automatic t_clear_oneshot();
    int n0;
    int n1;
    logic [15:0] rv;
    setup(MAX_COUNT, MAX_COUNT, 16'h0000, 16'h0004, mk_mode(MODE_EDGE_CLEAR, 1'b0, 1'b0));
    repeat (40) @(posedge clk);
    n0 = n_irq2;
    src.drive(1'b0, 1'b1);
    rd_reg(ADDR_COUNT, rv);
    `CHK(rv < 16'h001c, 1'b1)
    `CHK(n_irq2 - n0, 1)
    src.drive(1'b0, 1'b0);
    n0 = n_irq1;
    n1 = n_irq2;
    wr_reg(ADDR_MODE_CTRL, mk_mode(MODE_EDGE_CLEAR, 1'b0, 1'b1));
    rd_reg(ADDR_COUNT, rv);
    `CHK(rv < 16'h0004, 1'b1)
    repeat (2) @(posedge clk);
    `CHK(n_irq1 - n0, 1)
    `CHK(n_irq2 - n1, 1)
    $display("t_clear_oneshot finished");
  endtask

  task automatic t_wrap();
    int cyc;
    int n0;
    logic [15:0] rv;
    // both compares at zero: each fires only on the first step after the wrap
    setup(RST_WORD, RST_WORD, 16'h0000, 16'h0000, mk_mode(MODE_FREE_RUN, 1'b0, 1'b0));
    n0 = n_irq1;
    wait_irq(1'b1, 70000, cyc);
    `CHK(cyc > 65535, 1'b1)
    repeat (2) @(posedge clk);
    `CHK(n_irq1 - n0, 1)
    rd_reg(ADDR_MODE_CTRL, rv);
    `CHK(rv[0], 1'b1)
    // overflow bit is writable while running, like the mode and pin b fields
    wr_reg(ADDR_MODE_CTRL, mk_mode(MODE_FREE_RUN, 1'b0, 1'b0));
    rd_reg(ADDR_MODE_CTRL, rv);
    `CHK(rv[0], 1'b0)
    $display("t_wrap finished");
  endtask

  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_rate();
    t_match_clear();
    t_edges();
    t_clear_oneshot();
    t_wrap();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
